// ==== rtl/port_policy_pkg.sv ====
// Package with offsets, field positions and reset values of the policy bank
package port_policy_pkg;
  localparam int NUM_PORTS = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets, per port
  localparam logic [7:0] PORT1_CTRL_A_OFS = 8'h11;
  localparam logic [7:0] PORT1_CTRL_B_OFS = 8'h12;
  localparam logic [7:0] PORT2_CTRL_A_OFS = 8'h21;
  localparam logic [7:0] PORT2_CTRL_B_OFS = 8'h22;
  localparam logic [7:0] PORT3_CTRL_A_OFS = 8'h31;
  localparam logic [7:0] PORT3_CTRL_B_OFS = 8'h32;
  // First policy register fields
  localparam int MONITOR_PORT_BIT = 7;
  localparam int RX_SNIFF_BIT = 6;
  localparam int TX_SNIFF_BIT = 5;
  localparam int DOUBLE_TAG_BIT = 4;
  localparam int PRIO_CEIL_BIT = 3;
  localparam int MEMBER_HI = 2;
  localparam int MEMBER_LO = 0;
  // Second policy register fields
  localparam int TWO_Q_BIT = 7;
  localparam int INGRESS_VLAN_FILT_BIT = 6;
  localparam int DEF_VID_FILT_BIT = 5;
  localparam int FORCE_FC_BIT = 4;
  localparam int BACK_PRESS_BIT = 3;
  localparam int TX_EN_BIT = 2;
  localparam int RX_EN_BIT = 1;
  localparam int LEARN_DIS_BIT = 0;
  // Default tag high byte fields
  localparam int TAG_PRIO_HI = 7;
  localparam int TAG_PRIO_LO = 5;
  localparam int TAG_FMT_BIT = 4;
  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h07;
  localparam logic [7:0] CTRL_B_RST = 8'h06;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Reset values of the registered policy outputs
  localparam logic [8:0] MEMBER_OUT_RST = 9'h1FF;
  localparam logic [2:0] ENABLES_OUT_RST = 3'h7;
endpackage

// ==== rtl/port_policy_slice.sv ====
// One port's pair of policy registers with write address decode and strap capture
`timescale 1ns/10ps
module port_policy_slice
  import port_policy_pkg::*;
#(
  parameter logic [7:0] OFS_A = 8'h11,
  parameter logic [7:0] OFS_B = 8'h12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Management write port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  // Strap for forced flow control, caught after reset release
  input wire logic force_fc_strap,
  // Register contents
  output logic [DATA_W-1:0] ctrl_a_r,
  output logic [DATA_W-1:0] ctrl_b_r
);
  logic [DATA_W-1:0] ctrl_a_nxt; // Next first register
  logic [DATA_W-1:0] ctrl_b_nxt; // Next second register
  logic strap_done_r; // Strap already sampled
  logic strap_done_nxt;

  // Next values: strap once, then software writes
  always_comb begin
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    strap_done_nxt = 1'b1;
    if (!strap_done_r) begin
      // First edge after release takes the strap level
      ctrl_b_nxt[FORCE_FC_BIT] = force_fc_strap;
    end
    if (wr_en && addr == OFS_A) begin
      ctrl_a_nxt = wdata;
    end
    if (wr_en && addr == OFS_B) begin
      ctrl_b_nxt = wdata;
    end
  end

  // Registers; reset to documented defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_r <= CTRL_A_RST;
      ctrl_b_r <= CTRL_B_RST;
      strap_done_r <= 1'b0;
    end else begin
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  property p_write_a;
    @(posedge clk) disable iff (!rst_n)
      (wr_en && addr == OFS_A) |=> (ctrl_a_r == $past(wdata));
  endproperty
  a_write_a: assert property (p_write_a)
    else $error("first policy register write lost");

  property p_write_b;
    @(posedge clk) disable iff (!rst_n)
      (wr_en && addr == OFS_B && strap_done_r) |=>
        (ctrl_b_r == $past(wdata));
  endproperty
  a_write_b: assert property (p_write_b)
    else $error("second policy register write lost");
endmodule

// ==== rtl/port_forwarding_policy_regs.sv ====
// Three-port forwarding policy register bank with per-port decode outputs
// What this block does
// - Per-port first policy register at own address
// - Per-port second policy register at own address
// - Monitor bit makes port transmit monitored packets
// - Receive sniff marks ingress packets as monitored
// - Transmit sniff marks egress packets as monitored
// - Double tag adds default tag always
// - Priority ceiling clamps user priority to default
// - Egress membership mask, resets to all ones
// - Two-queue split, exclusive with four-queue split
// - Ingress VLAN filter drops non-member arrivals
// - Default VID filter drops mismatching VIDs
// - Force flow control overrides autonegotiation result
// - Back pressure enable, resets disabled
// - Transmit enable, resets enabled
// - Receive enable, resets enabled
// - Learning disable stops learning, resets zero
// - Four-queue split selected by other register
// - Default tag holds priority, format, VID top
`timescale 1ns/10ps
module port_forwarding_policy_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Management register port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [port_policy_pkg::ADDR_W-1:0] addr,
  input wire logic [port_policy_pkg::DATA_W-1:0] wdata,
  output logic [port_policy_pkg::DATA_W-1:0] rdata_r,
  // Per-port context from the rest of the switch
  input wire logic [2:0] four_q_split, // from other register
  input wire logic [2:0] force_fc_strap,
  input wire logic [2:0] autoneg_flow_ctrl, // autonegotiation_result
  input wire logic [23:0] default_tag_hi, // Default tag high bytes
  // Per-port packet under decision: priority, VLAN hit and VID match per port
  input wire logic [8:0] pkt_prio, // User priority, 3 bits a port
  input wire logic [2:0] pkt_vlan_member, // VLAN table hit for port
  input wire logic [2:0] pkt_vid_match, // VID equals port default
  // Policy outputs per port
  output logic [2:0] monitor_port_r,
  output logic [2:0] rx_monitor_r,
  output logic [2:0] tx_monitor_r,
  output logic [2:0] double_tag_r,
  output logic [8:0] prio_out_r,
  output logic [8:0] egress_member_r,
  output logic [2:0] two_q_split_r,
  output logic [2:0] split_conflict_r,
  output logic [2:0] drop_r,
  output logic [2:0] flow_ctrl_en_r,
  output logic [2:0] back_press_r,
  output logic [2:0] tx_en_r,
  output logic [2:0] rx_en_r,
  output logic [2:0] learn_en_r
);
  import port_policy_pkg::*;

  localparam logic [7:0] OFS_A [NUM_PORTS] = '{PORT1_CTRL_A_OFS,
    PORT2_CTRL_A_OFS, PORT3_CTRL_A_OFS};
  localparam logic [7:0] OFS_B [NUM_PORTS] = '{PORT1_CTRL_B_OFS,
    PORT2_CTRL_B_OFS, PORT3_CTRL_B_OFS};

  logic [DATA_W-1:0] ctrl_a [NUM_PORTS]; // First register per port
  logic [DATA_W-1:0] ctrl_b [NUM_PORTS]; // Second register per port

  // One slice per port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    port_policy_slice #(
      .OFS_A(OFS_A[p]),
      .OFS_B(OFS_B[p])
    ) u_slice (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(wr_en),
      .addr(addr),
      .wdata(wdata),
      .force_fc_strap(force_fc_strap[p]),
      .ctrl_a_r(ctrl_a[p]),
      .ctrl_b_r(ctrl_b[p])
    );
  end

  // Next values of read data and policy outputs
  logic [DATA_W-1:0] rdata_nxt;
  logic [2:0] monitor_port_nxt;
  logic [2:0] rx_monitor_nxt;
  logic [2:0] tx_monitor_nxt;
  logic [2:0] double_tag_nxt;
  logic [8:0] prio_out_nxt;
  logic [8:0] egress_member_nxt;
  logic [2:0] two_q_split_nxt;
  logic [2:0] split_conflict_nxt;
  logic [2:0] drop_nxt;
  logic [2:0] flow_ctrl_en_nxt;
  logic [2:0] back_press_nxt;
  logic [2:0] tx_en_nxt;
  logic [2:0] rx_en_nxt;
  logic [2:0] learn_en_nxt;

  // Read mux: unmapped addresses read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      rdata_nxt = READ_ZERO;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (addr == OFS_A[p]) begin
          rdata_nxt = ctrl_a[p];
        end
        if (addr == OFS_B[p]) begin
          rdata_nxt = ctrl_b[p];
        end
      end
    end
  end

  // Policy decode from live register contents
  always_comb begin
    logic [2:0] tag_prio;
    logic [2:0] in_prio;
    tag_prio = 3'h0;
    in_prio = 3'h0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      monitor_port_nxt[p] = ctrl_a[p][MONITOR_PORT_BIT];
      rx_monitor_nxt[p] = ctrl_a[p][RX_SNIFF_BIT];
      tx_monitor_nxt[p] = ctrl_a[p][TX_SNIFF_BIT];
      double_tag_nxt[p] = ctrl_a[p][DOUBLE_TAG_BIT];
      // Priority from the tag's top three bits
      tag_prio = default_tag_hi[p*8+TAG_PRIO_LO +: 3];
      in_prio = pkt_prio[p*3 +: 3];
      if (ctrl_a[p][PRIO_CEIL_BIT] && in_prio > tag_prio) begin
        prio_out_nxt[p*3 +: 3] = tag_prio;
      end else begin
        prio_out_nxt[p*3 +: 3] = in_prio; // No clamp
      end
      egress_member_nxt[p*3 +: 3] = ctrl_a[p][MEMBER_HI:MEMBER_LO];
      // Two-queue split is suppressed when four-queue also set
      two_q_split_nxt[p] = ctrl_b[p][TWO_Q_BIT] && !four_q_split[p];
      split_conflict_nxt[p] = ctrl_b[p][TWO_Q_BIT] && four_q_split[p];
      drop_nxt[p] =
        (ctrl_b[p][INGRESS_VLAN_FILT_BIT] && !pkt_vlan_member[p])
        || (ctrl_b[p][DEF_VID_FILT_BIT] && !pkt_vid_match[p]);
      flow_ctrl_en_nxt[p] = ctrl_b[p][FORCE_FC_BIT] || autoneg_flow_ctrl[p];
      back_press_nxt[p] = ctrl_b[p][BACK_PRESS_BIT];
      tx_en_nxt[p] = ctrl_b[p][TX_EN_BIT];
      rx_en_nxt[p] = ctrl_b[p][RX_EN_BIT];
      learn_en_nxt[p] = !ctrl_b[p][LEARN_DIS_BIT];
    end
  end
  // Flow control choice above: force wins, else negotiated

  // Output registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= READ_ZERO;
      monitor_port_r <= 3'h0;
      rx_monitor_r <= 3'h0;
      tx_monitor_r <= 3'h0;
      double_tag_r <= 3'h0;
      prio_out_r <= 9'h000;
      egress_member_r <= MEMBER_OUT_RST;
      two_q_split_r <= 3'h0;
      split_conflict_r <= 3'h0;
      drop_r <= 3'h0;
      flow_ctrl_en_r <= 3'h0;
      back_press_r <= 3'h0;
      tx_en_r <= ENABLES_OUT_RST;
      rx_en_r <= ENABLES_OUT_RST;
      learn_en_r <= ENABLES_OUT_RST;
    end else begin
      rdata_r <= rdata_nxt;
      monitor_port_r <= monitor_port_nxt;
      rx_monitor_r <= rx_monitor_nxt;
      tx_monitor_r <= tx_monitor_nxt;
      double_tag_r <= double_tag_nxt;
      prio_out_r <= prio_out_nxt;
      egress_member_r <= egress_member_nxt;
      two_q_split_r <= two_q_split_nxt;
      split_conflict_r <= split_conflict_nxt;
      drop_r <= drop_nxt;
      flow_ctrl_en_r <= flow_ctrl_en_nxt;
      back_press_r <= back_press_nxt;
      tx_en_r <= tx_en_nxt;
      rx_en_r <= rx_en_nxt;
      learn_en_r <= learn_en_nxt;
    end
  end

  // Write then read back returns the written byte
  sequence s_wr_a1;
    wr_en && addr == PORT1_CTRL_A_OFS;
  endsequence
  property p_readback;
    @(posedge clk) disable iff (!rst_n)
      s_wr_a1 ##1 (rd_en && !wr_en && addr == PORT1_CTRL_A_OFS) |=>
        rdata_r == $past(wdata, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("port 1 first register readback wrong");

  property p_monitor;
    @(posedge clk) disable iff (!rst_n)
      (wr_en && addr == PORT2_CTRL_A_OFS) |=> ##1
        (monitor_port_r[1] == $past(wdata[MONITOR_PORT_BIT], 2));
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("monitor port bit not applied");

  property p_rx_tx_sniff;
    @(posedge clk) disable iff (!rst_n)
      (wr_en && addr == PORT3_CTRL_A_OFS) |=> ##1
        (rx_monitor_r[2] == $past(wdata[RX_SNIFF_BIT], 2)) &&
        (tx_monitor_r[2] == $past(wdata[TX_SNIFF_BIT], 2));
  endproperty
  a_rx_tx_sniff: assert property (p_rx_tx_sniff)
    else $error("sniff bits not applied");

  property p_ceiling;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_a[0][PRIO_CEIL_BIT] &&
       pkt_prio[2:0] > default_tag_hi[TAG_PRIO_HI:TAG_PRIO_LO]) |=>
        prio_out_r[2:0] == $past(default_tag_hi[TAG_PRIO_HI:TAG_PRIO_LO]);
  endproperty
  a_ceiling: assert property (p_ceiling)
    else $error("priority ceiling not applied");

  property p_no_ceiling;
    @(posedge clk) disable iff (!rst_n)
      !ctrl_a[0][PRIO_CEIL_BIT] |=> prio_out_r[2:0] == $past(pkt_prio[2:0]);
  endproperty
  a_no_ceiling: assert property (p_no_ceiling)
    else $error("priority altered without ceiling");

  property p_split;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> !(two_q_split_r[0] && $past(four_q_split[0]));
  endproperty
  a_split: assert property (p_split)
    else $error("two and four queue split both active");

  property p_drop;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_b[1][INGRESS_VLAN_FILT_BIT] && !pkt_vlan_member[1]) ||
      (ctrl_b[1][DEF_VID_FILT_BIT] && !pkt_vid_match[1]) |=> drop_r[1];
  endproperty
  a_drop: assert property (p_drop)
    else $error("filtered packet not dropped");

  property p_flow;
    @(posedge clk) disable iff (!rst_n)
      ctrl_b[0][FORCE_FC_BIT] |=> flow_ctrl_en_r[0];
  endproperty
  a_flow: assert property (p_flow)
    else $error("forced flow control not enabled");

  property p_stp;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> tx_en_r[2] == $past(ctrl_b[2][TX_EN_BIT]) &&
        rx_en_r[2] == $past(ctrl_b[2][RX_EN_BIT]) &&
        learn_en_r[2] == !$past(ctrl_b[2][LEARN_DIS_BIT]);
  endproperty
  a_stp: assert property (p_stp)
    else $error("spanning tree controls not applied");

  // Read data stays put between reads
  property p_rdata_hold;
    @(posedge clk) disable iff (!rst_n)
      !rd_en |=> $stable(rdata_r);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  // Reads outside the six registers return zero
  sequence s_rd_unmapped;
    rd_en && addr != PORT1_CTRL_A_OFS && addr != PORT1_CTRL_B_OFS &&
      addr != PORT2_CTRL_A_OFS && addr != PORT2_CTRL_B_OFS &&
      addr != PORT3_CTRL_A_OFS && addr != PORT3_CTRL_B_OFS;
  endsequence
  property p_rd_unmapped;
    @(posedge clk) disable iff (!rst_n)
      s_rd_unmapped |=> rdata_r == READ_ZERO;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");

  // Tagging and membership follow a port 1 first register write
  property p_tag_member;
    @(posedge clk) disable iff (!rst_n)
      s_wr_a1 |=> ##1
        (double_tag_r[0] == $past(wdata[DOUBLE_TAG_BIT], 2)) &&
        (egress_member_r[2:0] == $past(wdata[MEMBER_HI:MEMBER_LO], 2));
  endproperty
  a_tag_member: assert property (p_tag_member)
    else $error("double tag or membership not applied");

  // Back pressure of port 2 follows its second register
  sequence s_wr_b2;
    wr_en && addr == PORT2_CTRL_B_OFS;
  endsequence
  property p_back_press;
    @(posedge clk) disable iff (!rst_n)
      s_wr_b2 |=> ##1
        (back_press_r[1] == $past(wdata[BACK_PRESS_BIT], 2));
  endproperty
  a_back_press: assert property (p_back_press)
    else $error("back pressure bit not applied");

  // Without the force bit, flow control tracks negotiation
  property p_flow_follow;
    @(posedge clk) disable iff (!rst_n)
      !ctrl_b[1][FORCE_FC_BIT] |=>
        flow_ctrl_en_r[1] == $past(autoneg_flow_ctrl[1]);
  endproperty
  a_flow_follow: assert property (p_flow_follow)
    else $error("flow control ignores negotiation");

  // Packets that pass both filters are kept
  property p_no_drop;
    @(posedge clk) disable iff (!rst_n)
      pkt_vlan_member[1] && pkt_vid_match[1] |=> !drop_r[1];
  endproperty
  a_no_drop: assert property (p_no_drop)
    else $error("member packet dropped");

  // Two-queue split granted when four-queue split is off
  property p_split_alone;
    @(posedge clk) disable iff (!rst_n)
      ctrl_b[1][TWO_Q_BIT] && !four_q_split[1] |=> two_q_split_r[1];
  endproperty
  a_split_alone: assert property (p_split_alone)
    else $error("two queue split not granted");

  // Both splits at once raise the conflict flag
  property p_split_conflict;
    @(posedge clk) disable iff (!rst_n)
      ctrl_b[2][TWO_Q_BIT] && four_q_split[2] |=> split_conflict_r[2];
  endproperty
  a_split_conflict: assert property (p_split_conflict)
    else $error("split conflict not flagged");

  // Port 2 ceiling clamps to its default tag priority
  sequence s_over_ceiling_p2;
    ctrl_a[1][PRIO_CEIL_BIT] &&
      pkt_prio[5:3] > default_tag_hi[DATA_W+TAG_PRIO_HI:DATA_W+TAG_PRIO_LO];
  endsequence
  property p_ceiling_p2;
    @(posedge clk) disable iff (!rst_n)
      s_over_ceiling_p2 |=> prio_out_r[5:3] ==
        $past(default_tag_hi[DATA_W+TAG_PRIO_HI:DATA_W+TAG_PRIO_LO]);
  endproperty
  a_ceiling_p2: assert property (p_ceiling_p2)
    else $error("port 2 priority ceiling not applied");
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the three-port forwarding policy register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import port_policy_pkg::*;
  // Clock, reset and bank ports
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata_r;
  logic [2:0] four_q_split = 3'h0;
  logic [2:0] force_fc_strap = 3'h1; // Port 1 strap high
  logic [2:0] autoneg_flow_ctrl = 3'h0;
  logic [23:0] default_tag_hi = 24'h006000; // Port 2 ceiling 3
  logic [8:0] pkt_prio = 9'h02F; // Port 2 prio 5, port 1 prio 7
  logic [2:0] pkt_vlan_member = 3'h0;
  logic [2:0] pkt_vid_match = 3'h0;
  logic [2:0] mon, rxm, txm, dtag, two_q, conf, drop, fc, bp, txe, rxe, lrn;
  logic [8:0] prio, memb;
  int mismatches = 0; // Failed comparisons
  int checks_done = 0; // All comparisons
  // Half period of 25 ns
  always #25 clk = ~clk;
  port_forwarding_policy_regs u_dut (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata_r(rdata_r), .four_q_split(four_q_split),
    .force_fc_strap(force_fc_strap), .autoneg_flow_ctrl(autoneg_flow_ctrl),
    .default_tag_hi(default_tag_hi), .pkt_prio(pkt_prio),
    .pkt_vlan_member(pkt_vlan_member), .pkt_vid_match(pkt_vid_match),
    .monitor_port_r(mon), .rx_monitor_r(rxm), .tx_monitor_r(txm),
    .double_tag_r(dtag), .prio_out_r(prio), .egress_member_r(memb),
    .two_q_split_r(two_q), .split_conflict_r(conf), .drop_r(drop),
    .flow_ctrl_en_r(fc), .back_press_r(bp), .tx_en_r(txe), .rx_en_r(rxe),
    .learn_en_r(lrn));
  // One write cycle, launched and released on falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  // One read cycle, data judged one edge later
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    `CHK(n, e, rdata_r)
  endtask
  // Reset values of both registers of every port and their decode
  task automatic t_reset;
    rd(PORT1_CTRL_A_OFS, 8'h07, "p1 a rst");
    rd(PORT2_CTRL_A_OFS, 8'h07, "p2 a rst");
    rd(PORT3_CTRL_A_OFS, 8'h07, "p3 a rst");
    rd(PORT1_CTRL_B_OFS, 8'h16, "p1 b rst");
    rd(PORT2_CTRL_B_OFS, 8'h06, "p2 b rst");
    rd(PORT3_CTRL_B_OFS, 8'h06, "p3 b rst");
    `CHK("memb rst", 9'h1FF, memb)
    `CHK("txe rst", 3'h7, txe)
    `CHK("rxe rst", 3'h7, rxe)
    `CHK("lrn rst", 3'h7, lrn)
    `CHK("bp rst", 3'h0, bp)
    `CHK("mon rst", 3'h0, mon)
    `CHK("fc rst", 3'h1, fc)
    $display("test reset done");
  endtask
  // Unmapped place reads zero and leaves neighbours alone
  task automatic t_unmapped;
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h00, "unmapped");
    rd(PORT1_CTRL_A_OFS, 8'h07, "p1 a kept");
    $display("test unmapped done");
  endtask
  // First register: mirroring, tagging, ceiling and membership per port
  task automatic t_reg_a;
    wr(PORT1_CTRL_A_OFS, 8'hE5);
    wr(PORT2_CTRL_A_OFS, 8'h1A);
    wr(PORT3_CTRL_A_OFS, 8'h00);
    @(negedge clk);
    `CHK("mon", 3'h1, mon)
    `CHK("rx sniff", 3'h1, rxm)
    `CHK("tx sniff", 3'h1, txm)
    `CHK("dtag", 3'h2, dtag)
    `CHK("memb", 9'h015, memb)
    `CHK("prio clamp", 9'h01F, prio)
    pkt_prio = 9'h017; // Port 2 prio 2, below its ceiling
    @(negedge clk);
    @(negedge clk);
    `CHK("prio pass", 9'h017, prio)
    rd(PORT2_CTRL_A_OFS, 8'h1A, "p2 a");
    $display("test reg a done");
  endtask
  // Second register: split, filters, flow control, spanning tree bits
  task automatic t_reg_b;
    four_q_split = 3'h4;
    autoneg_flow_ctrl = 3'h2;
    wr(PORT1_CTRL_B_OFS, 8'h41);
    wr(PORT2_CTRL_B_OFS, 8'hA8);
    wr(PORT3_CTRL_B_OFS, 8'h94);
    @(negedge clk);
    `CHK("two q", 3'h2, two_q)
    `CHK("conflict", 3'h4, conf)
    `CHK("drop", 3'h3, drop)
    `CHK("fc", 3'h6, fc)
    `CHK("bp", 3'h2, bp)
    `CHK("txe", 3'h4, txe)
    `CHK("rxe", 3'h0, rxe)
    `CHK("lrn", 3'h6, lrn)
    pkt_vlan_member = 3'h7;
    pkt_vid_match = 3'h7;
    @(negedge clk);
    @(negedge clk);
    `CHK("no drop", 3'h0, drop)
    rd(PORT3_CTRL_B_OFS, 8'h94, "p3 b");
    $display("test reg b done");
  endtask
  // Write and read in one cycle, then the new value without any reset
  task automatic t_b2b;
    @(negedge clk);
    wr_en = 1'b1;
    rd_en = 1'b1;
    addr = PORT2_CTRL_B_OFS;
    wdata = 8'h06;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b0;
    `CHK("read old", 8'hA8, rdata_r)
    @(negedge clk);
    `CHK("bp off", 3'h0, bp)
    rd(PORT2_CTRL_B_OFS, 8'h06, "read new");
    $display("test back to back done");
  endtask
  // Read straight after a write; port 1 ceiling clamps priority 7 to 0
  task automatic t_wr_rd;
    @(negedge clk);
    wr_en = 1'b1;
    addr = PORT1_CTRL_A_OFS;
    wdata = 8'h5A;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    `CHK("rd after wr", 8'h5A, rdata_r)
    `CHK("p1 clamp", 9'h010, prio)
    `CHK("dtag p1", 3'h3, dtag)
    $display("test write then read done");
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_unmapped();
    t_reg_a();
    t_reg_b();
    t_b2b();
    t_wr_rd();
    tally_and_finish();
  end
endmodule
